// ===== src/opm_defines.svh
// timing counts, polling defaults and service layout for the mode controller
`ifndef OPM_DEFINES_SVH
`define OPM_DEFINES_SVH
`define OPM_CLK_MHZ 100
`define OPM_INIT_NS 2000
`define OPM_INIT_CYC ((`OPM_INIT_NS * `OPM_CLK_MHZ + 999) / 1000)
`define OPM_LOAD_NS 100
`define OPM_LOAD_CYC ((`OPM_LOAD_NS * `OPM_CLK_MHZ + 999) / 1000)
`define OPM_TC_NS 500
`define OPM_TC_CYC ((`OPM_TC_NS * `OPM_CLK_MHZ + 999) / 1000)
`define OPM_POLL_ON_DEF 16'h0100
`define OPM_POLL_SLEEP_DEF 16'h1000
`define OPM_TC_EVERY_DEF 8'h04
`define OPM_NUM_SVC 5
`define OPM_NUM_ROM_SVC 3
`define OPM_SVC_W 16
`endif

// ===== src/opm_pkg.sv
// types for the operating mode controller
package opm_pkg;
    typedef enum logic [2:0] {
        OPM_CMD_NONE,
        OPM_CMD_TX,
        OPM_CMD_RX,
        OPM_CMD_POLL,
        OPM_CMD_TC,
        OPM_CMD_IDLE
    } opm_cmd_t;
    typedef enum logic [1:0] {
        OPM_START_IDLE,
        OPM_START_TX,
        OPM_START_RX,
        OPM_START_POLL
    } opm_start_t;
    typedef enum logic [2:0] {
        OPM_M_OFF,
        OPM_M_IDLE,
        OPM_M_TX,
        OPM_M_RX,
        OPM_M_POLL_ACT,
        OPM_M_POLL_SLP,
        OPM_M_TC
    } opm_mode_t;
endpackage

// ===== src/opm_sync.sv
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module opm_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    input wire logic rst_val_i,
    output logic sync_o
);
    logic s1_q, s2_q, s3_q, out_q;
    logic out_d;
    always_comb begin
        out_d = out_q;
        if (s2_q == s3_q) begin
            out_d = s3_q;
        end
    end
    // reset value is a constant per instance, never a sampled level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            out_q <= 1'b1;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end
    assign sync_o = rst_val_i ? out_q : ~out_q;
endmodule // opm_sync

// ===== src/opm_svc_store.sv
// five service words: three fixed, two writable; current-service copy
`timescale 1ns/1ns
`include "opm_defines.svh"
module opm_svc_store (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`OPM_SVC_W*3-1:0] rom_svc_i,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_sel_i,
    input wire logic [`OPM_SVC_W-1:0] wr_data_i,
    input wire logic load_i,
    input wire logic [2:0] load_sel_i,
    output logic [`OPM_SVC_W-1:0] cur_svc_o,
    output logic wr_rej_o
);
    logic [`OPM_SVC_W-1:0] ram_q [2];
    logic [`OPM_SVC_W-1:0] ram_d [2];
    logic [`OPM_SVC_W-1:0] cur_q, cur_d;
    logic rej_q, rej_d;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ram
            always_comb begin
                ram_d[g] = ram_q[g];
                if (wr_en_i && wr_sel_i == 3'(g + `OPM_NUM_ROM_SVC)) begin
                    ram_d[g] = wr_data_i;
                end
            end
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ram_q[g] <= 16'h0000;
                end else begin
                    ram_q[g] <= ram_d[g];
                end
            end
        end
    endgenerate
    always_comb begin
        cur_d = cur_q;
        // fixed services never take a write; such an attempt is flagged
        rej_d = wr_en_i && (wr_sel_i < 3'(`OPM_NUM_ROM_SVC) || wr_sel_i >= 3'(`OPM_NUM_SVC));
        if (load_i) begin
            if (load_sel_i < 3'(`OPM_NUM_ROM_SVC)) begin
                cur_d = rom_svc_i[load_sel_i[1:0]*`OPM_SVC_W +: `OPM_SVC_W];
            end else if (load_sel_i == 3'h3) begin
                cur_d = ram_q[0];
            end else begin
                cur_d = ram_q[1];
            end
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_q <= 16'h0000;
            rej_q <= 1'b0;
        end else begin
            cur_q <= cur_d;
            rej_q <= rej_d;
        end
    end
    assign cur_svc_o = cur_q;
    assign wr_rej_o = rej_q;
endmodule // opm_svc_store

// ===== src/opm_ctrl.sv
// operating mode controller: power-on sequence, mode hub, supply and oscillator enables
// Functional notes
// - supply applied always lands in power-off state.
// - power-off state switches every supply and oscillator off.
// - no command is taken in power-off; host must not send then.
// - high wake pin or any low wake pin starts power-on.
// - after init go to standby unless start configuration says otherwise; tune-check at init set goes to tune-check, then standby.
// - standby takes commands and leads to every other state.
// - a configuration bit selects the rc standby variant on slow rc.
// - crystal standby variant keeps crystal running.
// - transmit entered by host command or directly after power-on.
// - receive scans continuously; telegram accepted only on preamble and checks.
// - polling runs receiver briefly, sleeps configured period, repeats.
// - polling config copied to working copy at init, editable in standby.
// - tune-check on command, at init if set, periodically in polling.
// - supply and oscillator enables follow the mode table.
// - amplifier supply on in transmit only with high-voltage bit set.
// - processor sleeps in standby with configured sleep mode.
// - five services; three fixed, two writable only in standby.
// - transmit or receive start loads selected service to current, then hardware.
`timescale 1ns/1ns
`include "opm_defines.svh"
module opm_ctrl (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wake_high_pin_i,
    input wire logic [5:0] wake_low_pins_n_i,
    input wire logic cfg_crystal_standby_i,
    input wire logic high_voltage_app_bit_i,
    input wire logic [1:0] cfg_sleep_mode_i,
    input wire opm_pkg::opm_start_t cfg_start_i,
    input wire logic cfg_tc_at_init_i,
    input wire logic cfg_tc_in_poll_i,
    input wire logic [15:0] nv_poll_on_i,
    input wire logic [15:0] nv_poll_sleep_i,
    input wire logic [`OPM_SVC_W*3-1:0] nv_svc_i,
    input wire logic cmd_valid_i,
    input wire opm_pkg::opm_cmd_t cmd_i,
    input wire logic [2:0] cmd_svc_i,
    input wire logic poll_wr_i,
    input wire logic [15:0] poll_on_wr_i,
    input wire logic [15:0] poll_sleep_wr_i,
    input wire logic svc_wr_i,
    input wire logic [2:0] svc_wr_sel_i,
    input wire logic [`OPM_SVC_W-1:0] svc_wr_data_i,
    input wire logic preamble_ok_i,
    input wire logic checks_ok_i,
    input wire logic telegram_done_i,
    input wire logic shutdown_i,
    output opm_pkg::opm_mode_t mode_o,
    output logic cmd_ready_o,
    output logic digital_supply_o,
    output logic analog_supply_o,
    output logic amp_supply_o,
    output logic crystal_osc_o,
    output logic slow_rc_osc_o,
    output logic fast_rc_osc_o,
    output logic cpu_sleep_o,
    output logic [1:0] cpu_sleep_mode_o,
    output logic rx_enable_o,
    output logic rx_accept_o,
    output logic hw_load_o,
    output logic [`OPM_SVC_W-1:0] hw_svc_o,
    output logic svc_wr_rej_o
);
    import opm_pkg::*;

    logic wake_hi_s;
    logic [5:0] wake_lo_s;
    logic init_q, init_d;
    logic loading_q, loading_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] poll_on_q, poll_on_d;
    logic [15:0] poll_sleep_q, poll_sleep_d;
    logic [7:0] poll_n_q, poll_n_d;
    logic [2:0] sel_q, sel_d;
    opm_mode_t mode_q, mode_d, pend_q, pend_d;
    logic svc_load;
    logic [`OPM_SVC_W-1:0] cur_svc;
    logic svc_rej;
    logic wake;
    logic cmd_take;
    logic rdy_q, rdy_d, dsup_q, dsup_d, asup_q, asup_d, amp_q, amp_d;
    logic xto_q, xto_d, src_q, src_d, frc_q, frc_d, slp_q, slp_d;
    logic rxe_q, rxe_d, acc_q, acc_d, hwl_q, hwl_d;
    logic [1:0] smode_q, smode_d;

    // wake pins come from outside: synchronised, reset value is their idle level
    opm_sync u_sync_hi (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(~wake_high_pin_i),
        .rst_val_i(1'b0),
        .sync_o(wake_hi_s)
    );
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_wake
            opm_sync u_sync_lo (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .async_i(wake_low_pins_n_i[g]),
                .rst_val_i(1'b1),
                .sync_o(wake_lo_s[g])
            );
        end
    endgenerate

    assign wake = wake_hi_s || (wake_lo_s != 6'h3F);
    assign cmd_take = cmd_valid_i && mode_q == OPM_M_IDLE && !init_q && !loading_q;

    opm_svc_store u_svc (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .rom_svc_i(nv_svc_i),
        .wr_en_i(svc_wr_i && mode_q == OPM_M_IDLE && !init_q),
        .wr_sel_i(svc_wr_sel_i),
        .wr_data_i(svc_wr_data_i),
        .load_i(svc_load),
        .load_sel_i(sel_d),
        .cur_svc_o(cur_svc),
        .wr_rej_o(svc_rej)
    );

    always_comb begin
        mode_d = mode_q;
        pend_d = pend_q;
        init_d = init_q;
        loading_d = loading_q;
        cnt_d = cnt_q;
        sel_d = sel_q;
        poll_on_d = poll_on_q;
        poll_sleep_d = poll_sleep_q;
        poll_n_d = poll_n_q;
        svc_load = 1'b0;
        case (mode_q)
            OPM_M_OFF: begin
                if (wake) begin
                    mode_d = OPM_M_IDLE;
                    init_d = 1'b1;
                    cnt_d = 16'(`OPM_INIT_CYC);
                    // working polling config taken from storage
                    poll_on_d = nv_poll_on_i;
                    poll_sleep_d = nv_poll_sleep_i;
                    poll_n_d = 8'h00;
                end
            end
            OPM_M_IDLE: begin
                if (init_q || loading_q) begin
                    if (cnt_q != 16'h0000) begin
                        cnt_d = cnt_q - 16'h0001;
                    end else if (init_q) begin
                        init_d = 1'b0;
                        if (cfg_tc_at_init_i) begin
                            pend_d = OPM_M_TC;
                        end else begin
                            case (cfg_start_i)
                                OPM_START_TX: pend_d = OPM_M_TX;
                                OPM_START_RX: pend_d = OPM_M_RX;
                                OPM_START_POLL: pend_d = OPM_M_POLL_ACT;
                                default: pend_d = OPM_M_IDLE;
                            endcase
                        end
                        if (pend_d == OPM_M_TX || pend_d == OPM_M_RX) begin
                            loading_d = 1'b1;
                            cnt_d = 16'(`OPM_LOAD_CYC);
                            svc_load = 1'b1;
                        end else if (pend_d == OPM_M_TC) begin
                            mode_d = OPM_M_TC;
                            cnt_d = 16'(`OPM_TC_CYC);
                        end else begin
                            mode_d = pend_d;
                            cnt_d = poll_on_q;
                        end
                    end else begin
                        // service copied, hardware load then enters mode
                        loading_d = 1'b0;
                        mode_d = pend_q;
                    end
                end else if (shutdown_i) begin
                    mode_d = OPM_M_OFF;
                end else if (poll_wr_i) begin
                    poll_on_d = poll_on_wr_i;
                    poll_sleep_d = poll_sleep_wr_i;
                end else if (cmd_take) begin
                    case (cmd_i)
                        OPM_CMD_TX, OPM_CMD_RX: begin
                            sel_d = cmd_svc_i;
                            pend_d = (cmd_i == OPM_CMD_TX) ? OPM_M_TX : OPM_M_RX;
                            loading_d = 1'b1;
                            cnt_d = 16'(`OPM_LOAD_CYC);
                            svc_load = 1'b1;
                        end
                        OPM_CMD_POLL: begin
                            mode_d = OPM_M_POLL_ACT;
                            cnt_d = poll_on_q;
                            poll_n_d = 8'h00;
                        end
                        OPM_CMD_TC: begin
                            mode_d = OPM_M_TC;
                            cnt_d = 16'(`OPM_TC_CYC);
                        end
                        default: mode_d = OPM_M_IDLE;
                    endcase
                end
            end
            OPM_M_TX: begin
                if (telegram_done_i || (cmd_valid_i && cmd_i == OPM_CMD_IDLE)) begin
                    mode_d = OPM_M_IDLE;
                end
            end
            OPM_M_RX: begin
                if (cmd_valid_i && cmd_i == OPM_CMD_IDLE) begin
                    mode_d = OPM_M_IDLE;
                end
            end
            // active window, then sleep, then repeat
            OPM_M_POLL_ACT: begin
                if (cmd_valid_i && cmd_i == OPM_CMD_IDLE) begin
                    mode_d = OPM_M_IDLE;
                end else if (preamble_ok_i) begin
                    cnt_d = cnt_q;
                end else if (cnt_q != 16'h0000) begin
                    cnt_d = cnt_q - 16'h0001;
                end else begin
                    mode_d = OPM_M_POLL_SLP;
                    cnt_d = poll_sleep_q;
                end
            end
            OPM_M_POLL_SLP: begin
                if (cmd_valid_i && cmd_i == OPM_CMD_IDLE) begin
                    mode_d = OPM_M_IDLE;
                end else if (cnt_q != 16'h0000) begin
                    cnt_d = cnt_q - 16'h0001;
                end else if (cfg_tc_in_poll_i && poll_n_q >= `OPM_TC_EVERY_DEF - 8'h01) begin
                    poll_n_d = 8'h00;
                    mode_d = OPM_M_TC;
                    pend_d = OPM_M_POLL_ACT;
                    cnt_d = 16'(`OPM_TC_CYC);
                end else begin
                    poll_n_d = poll_n_q + 8'h01;
                    mode_d = OPM_M_POLL_ACT;
                    cnt_d = poll_on_q;
                end
            end
            OPM_M_TC: begin
                if (cnt_q != 16'h0000) begin
                    cnt_d = cnt_q - 16'h0001;
                end else if (pend_q == OPM_M_POLL_ACT) begin
                    mode_d = OPM_M_POLL_ACT;
                    cnt_d = poll_on_q;
                    pend_d = OPM_M_IDLE;
                end else begin
                    mode_d = OPM_M_IDLE;
                end
            end
            default: mode_d = OPM_M_OFF;
        endcase
    end

    // enables per mode
    always_comb begin
        rdy_d = mode_d == OPM_M_IDLE && !init_d && !loading_d;
        dsup_d = mode_d != OPM_M_OFF;
        asup_d = 1'b0;
        amp_d = 1'b0;
        xto_d = 1'b0;
        src_d = mode_d != OPM_M_OFF;
        frc_d = 1'b0;
        slp_d = 1'b0;
        rxe_d = 1'b0;
        acc_d = 1'b0;
        hwl_d = svc_load;
        smode_d = cfg_sleep_mode_i;
        case (mode_d)
            OPM_M_IDLE, OPM_M_POLL_SLP: begin
                asup_d = cfg_crystal_standby_i;
                xto_d = cfg_crystal_standby_i;
                frc_d = (init_d || loading_d) && !cfg_crystal_standby_i;
                slp_d = !init_d && !loading_d;
            end
            OPM_M_TX: begin
                asup_d = 1'b1;
                xto_d = 1'b1;
                // amplifier supply gated by high-voltage bit
                amp_d = high_voltage_app_bit_i;
            end
            OPM_M_RX, OPM_M_POLL_ACT: begin
                asup_d = 1'b1;
                xto_d = 1'b1;
                frc_d = mode_d == OPM_M_POLL_ACT && !cfg_crystal_standby_i;
                rxe_d = 1'b1;
                // accept only on preamble and passed checks
                acc_d = preamble_ok_i && checks_ok_i;
            end
            OPM_M_TC: begin
                asup_d = 1'b1;
                xto_d = 1'b1;
            end
            default: src_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= OPM_M_OFF;
            pend_q <= OPM_M_IDLE;
            init_q <= 1'b0;
            loading_q <= 1'b0;
            cnt_q <= 16'h0000;
            sel_q <= 3'h0;
            poll_on_q <= `OPM_POLL_ON_DEF;
            poll_sleep_q <= `OPM_POLL_SLEEP_DEF;
            poll_n_q <= 8'h00;
            rdy_q <= 1'b0;
            dsup_q <= 1'b0;
            asup_q <= 1'b0;
            amp_q <= 1'b0;
            xto_q <= 1'b0;
            src_q <= 1'b0;
            frc_q <= 1'b0;
            slp_q <= 1'b0;
            rxe_q <= 1'b0;
            acc_q <= 1'b0;
            hwl_q <= 1'b0;
            smode_q <= 2'h0;
        end else begin
            mode_q <= mode_d;
            pend_q <= pend_d;
            init_q <= init_d;
            loading_q <= loading_d;
            cnt_q <= cnt_d;
            sel_q <= sel_d;
            poll_on_q <= poll_on_d;
            poll_sleep_q <= poll_sleep_d;
            poll_n_q <= poll_n_d;
            rdy_q <= rdy_d;
            dsup_q <= dsup_d;
            asup_q <= asup_d;
            amp_q <= amp_d;
            xto_q <= xto_d;
            src_q <= src_d;
            frc_q <= frc_d;
            slp_q <= slp_d;
            rxe_q <= rxe_d;
            acc_q <= acc_d;
            hwl_q <= hwl_d;
            smode_q <= smode_d;
        end
    end

    assign mode_o = mode_q;
    assign cmd_ready_o = rdy_q;
    assign digital_supply_o = dsup_q;
    assign analog_supply_o = asup_q;
    assign amp_supply_o = amp_q;
    assign crystal_osc_o = xto_q;
    assign slow_rc_osc_o = src_q;
    assign fast_rc_osc_o = frc_q;
    assign cpu_sleep_o = slp_q;
    assign cpu_sleep_mode_o = smode_q;
    assign rx_enable_o = rxe_q;
    assign rx_accept_o = acc_q;
    assign hw_load_o = hwl_q;
    assign hw_svc_o = cur_svc;
    assign svc_wr_rej_o = svc_rej;
endmodule // opm_ctrl

// ===== testbench/opm_ctrl_monitor.sv
// port-level checks of the operating mode controller
`timescale 1ns/1ns
module opm_ctrl_monitor
    import opm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cfg_crystal_standby_i,
    input wire logic [1:0] cfg_sleep_mode_i,
    input wire logic cmd_valid_i,
    input wire opm_pkg::opm_cmd_t cmd_i,
    input wire logic svc_wr_i,
    input wire logic [2:0] svc_wr_sel_i,
    input wire opm_pkg::opm_mode_t mode_o,
    input wire logic cmd_ready_o,
    input wire logic digital_supply_o,
    input wire logic analog_supply_o,
    input wire logic amp_supply_o,
    input wire logic crystal_osc_o,
    input wire logic slow_rc_osc_o,
    input wire logic fast_rc_osc_o,
    input wire logic [1:0] cpu_sleep_mode_o,
    input wire logic hw_load_o,
    input wire logic svc_wr_rej_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_tx_take;
        cmd_valid_i && cmd_ready_o && cmd_i == OPM_CMD_TX;
    endsequence
    sequence s_tx_load;
        hw_load_o ##[10:12] mode_o == OPM_M_TX;
    endsequence
    AST_OFF_ALL: assert property (mode_o == OPM_M_OFF |-> !(digital_supply_o ||
        analog_supply_o || amp_supply_o || crystal_osc_o || slow_rc_osc_o || fast_rc_osc_o))
        else $error("supply on in power-off");
    AST_OFF_NO_CMD: assert property (mode_o == OPM_M_OFF |-> !cmd_ready_o)
        else $error("ready in power-off");
    AST_OFF_EXIT: assert property ($past(mode_o) == OPM_M_OFF && mode_o != OPM_M_OFF
        |-> mode_o == OPM_M_IDLE) else $error("power-on skipped standby");
    AST_READY_HUB: assert property (cmd_ready_o |-> mode_o == OPM_M_IDLE)
        else $error("ready outside standby");
    AST_STANDBY_VAR: assert property (cmd_ready_o |-> digital_supply_o && slow_rc_osc_o
        && crystal_osc_o == cfg_crystal_standby_i && analog_supply_o == cfg_crystal_standby_i)
        else $error("standby variant wrong");
    AST_TXRX_TABLE: assert property (mode_o inside {OPM_M_TX, OPM_M_RX} |-> analog_supply_o
        && crystal_osc_o && slow_rc_osc_o && !fast_rc_osc_o) else $error("tx rx table wrong");
    AST_AMP_TX: assert property (amp_supply_o |-> mode_o == OPM_M_TX)
        else $error("amp supply outside transmit");
    AST_SLEEP_SEL: assert property ($past(rst_n_i)
        |-> cpu_sleep_mode_o == $past(cfg_sleep_mode_i))
        else $error("sleep mode not passed");
    AST_SVC_REJ: assert property (svc_wr_i && cmd_ready_o && svc_wr_sel_i < 3'h3
        |=> svc_wr_rej_o) else $error("fixed service write not refused");
    AST_TX_LOAD: assert property (s_tx_take |=> s_tx_load)
        else $error("transmit load order wrong");
    AST_VIA_HUB: assert property ($past(mode_o) inside {OPM_M_TX, OPM_M_RX}
        && mode_o != $past(mode_o) |-> mode_o == OPM_M_IDLE) else $error("left tx rx not to standby");
endmodule // opm_ctrl_monitor
bind opm_ctrl opm_ctrl_monitor opm_ctrl_monitor_inst (.clk_i, .rst_n_i, .cfg_crystal_standby_i,
    .cfg_sleep_mode_i, .cmd_valid_i, .cmd_i, .svc_wr_i, .svc_wr_sel_i, .mode_o, .cmd_ready_o,
    .digital_supply_o, .analog_supply_o, .amp_supply_o, .crystal_osc_o, .slow_rc_osc_o,
    .fast_rc_osc_o, .cpu_sleep_mode_o, .hw_load_o, .svc_wr_rej_o);

// ===== testbench/opm_host_model.sv
// host model: issues one command and holds it until the controller takes it
`timescale 1ns/1ns
module opm_host_model
    import opm_pkg::*;
(
    input wire logic clk_i,
    input wire logic ready_i,
    output opm_pkg::opm_cmd_t cmd_o,
    output logic [2:0] svc_o,
    output logic valid_o
);
    initial begin
        valid_o = 1'b0;
        cmd_o = OPM_CMD_NONE;
        svc_o = 3'h0;
    end
    // request only once ready; stop is taken at any edge
    task automatic send(input opm_cmd_t c, input logic [2:0] s, input int gap);
        logic r;
        int n;
        n = 0;
        repeat (gap) @(posedge clk_i);
        while (c != OPM_CMD_IDLE && ready_i !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        #1;
        valid_o = 1'b1;
        cmd_o = c;
        svc_o = s;
        do begin
            r = (c == OPM_CMD_IDLE) || (ready_i === 1'b1);
            @(posedge clk_i);
        end while (!r);
        #1;
        valid_o = 1'b0;
        cmd_o = OPM_CMD_NONE;
        // released lines must not keep showing the old service
        svc_o = ~s;
    endtask
endmodule // opm_host_model

// ===== testbench/opm_ctrl_tb.sv
// self-checking bench for the operating mode controller
`timescale 1ns/1ns
module opm_ctrl_tb;
    import opm_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, wake_hi = 1'b0, xtal = 1'b0, hv = 1'b0;
    logic pre = 1'b0, chk_ok = 1'b0, done = 1'b0, shut = 1'b0, wr = 1'b0, pw = 1'b0;
    logic [5:0] wake_lo_n = 6'h3F;
    logic [1:0] slp = 2'h0;
    opm_start_t start = OPM_START_IDLE;
    logic [47:0] nv_svc = 48'h0;
    logic [15:0] poll_on = 16'h0010, poll_slp = 16'h0020, wr_data = 16'h0;
    logic [2:0] wr_sel = 3'h0, s;
    logic [15:0] ram_svc [3:4];
    opm_cmd_t cmd;
    opm_mode_t mode;
    logic [2:0] cmd_svc;
    logic cmd_valid, ready, dig, ana, amp, crystal_osc, src, fast_rc_osc, cpu_slp, rx_en, rx_acc, hw_load, rej;
    logic [15:0] hw_svc;
    int failures = 0, comparisons = 0, cycles = 0;
    always #5 clk_i = ~clk_i;
    opm_ctrl opm_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .wake_high_pin_i(wake_hi),
        .wake_low_pins_n_i(wake_lo_n), .cfg_crystal_standby_i(xtal), .high_voltage_app_bit_i(hv),
        .cfg_sleep_mode_i(slp), .cfg_start_i(start), .cfg_tc_at_init_i(1'b0),
        .cfg_tc_in_poll_i(1'b0), .nv_poll_on_i(poll_on), .nv_poll_sleep_i(poll_slp),
        .nv_svc_i(nv_svc), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_svc_i(cmd_svc),
        .poll_wr_i(pw), .poll_on_wr_i(16'h0006), .poll_sleep_wr_i(16'h0009), .svc_wr_i(wr),
        .svc_wr_sel_i(wr_sel), .svc_wr_data_i(wr_data), .preamble_ok_i(pre),
        .checks_ok_i(chk_ok), .telegram_done_i(done), .shutdown_i(shut), .mode_o(mode),
        .cmd_ready_o(ready), .digital_supply_o(dig), .analog_supply_o(ana), .amp_supply_o(amp),
        .crystal_osc_o(crystal_osc), .slow_rc_osc_o(src), .fast_rc_osc_o(fast_rc_osc), .cpu_sleep_o(cpu_slp),
        .cpu_sleep_mode_o(), .rx_enable_o(rx_en), .rx_accept_o(rx_acc), .hw_load_o(hw_load),
        .hw_svc_o(hw_svc), .svc_wr_rej_o(rej));
    opm_host_model opm_host_model_inst (.clk_i(clk_i), .ready_i(ready), .cmd_o(cmd),
        .svc_o(cmd_svc), .valid_o(cmd_valid));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_mode(input opm_mode_t m, input int lim);
        for (int n = 0; n < lim && mode !== m; n++) ticks(1);
        check(mode, m, "mode");
    endtask
    task automatic wait_ready(input int lim);
        for (int n = 0; n < lim && ready !== 1'b1; n++) ticks(1);
        check(ready, 1'b1, "ready");
    endtask
    task automatic wake(input logic hi);
        if (hi) wake_hi = 1'b1;
        else wake_lo_n[$urandom % 6] = 1'b0;
        ticks(8);
        wake_hi = 1'b0;
        wake_lo_n = 6'h3F;
    endtask
    function automatic logic [15:0] exp_svc(input logic [2:0] sel);
        return (sel < 3'h3) ? nv_svc[16*sel +: 16] : ram_svc[sel];
    endfunction
    // hang guard, well beyond the planned sequence
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(32'h445C23AF));
        ticks(10);
        rst_n_i = 1'b1;
        ticks(20);
        check(mode, OPM_M_OFF, "start off");
        check({dig, src, ready}, 3'h0, "off outputs");
        nv_svc = {16'($urandom), 32'($urandom)};
        slp = 2'($urandom);
        poll_on = 16'(8 + $urandom % 24);
        wake(1'b0);
        wait_mode(OPM_M_IDLE, 10);
        wait_ready(300);
        check(cpu_slp, 1'b1, "cpu sleeps");
        for (int i = 0; i < 6; i++) begin
            wr_sel = 3'(i);
            wr_data = 16'($urandom);
            wr = 1'b1;
            ticks(1);
            check(rej, (i < 3 || i > 4), "write refusal");
            if (i == 3 || i == 4) ram_svc[i] = wr_data;
        end
        wr = 1'b0;
        for (int i = 0; i < 5; i++) begin
            s = (i == 0) ? 3'h4 : 3'($urandom % 5);
            hv = 1'($urandom);
            opm_host_model_inst.send(OPM_CMD_TX, s, 1 + $urandom % 3);
            wait_mode(OPM_M_TX, 20);
            check(hw_svc, exp_svc(s), "tx service");
            check(amp, hv, "amp supply");
            done = 1'b1;
            ticks(1);
            done = 1'b0;
            wait_ready(20);
        end
        s = 3'($urandom % 5);
        opm_host_model_inst.send(OPM_CMD_RX, s, 1);
        wait_mode(OPM_M_RX, 20);
        check(hw_svc, exp_svc(s), "rx service");
        pre = 1'b1;
        ticks(3);
        check(rx_acc, 1'b0, "accept without checks");
        chk_ok = 1'b1;
        ticks(3);
        check(rx_acc, 1'b1, "accept");
        pre = 1'b0;
        chk_ok = 1'b0;
        opm_host_model_inst.send(OPM_CMD_IDLE, 3'h0, 1);
        wait_ready(20);
        pw = 1'b1;
        ticks(1);
        pw = 1'b0;
        opm_host_model_inst.send(OPM_CMD_POLL, 3'h0, 2);
        wait_mode(OPM_M_POLL_ACT, 4);
        check(rx_en, 1'b1, "poll window");
        wait_mode(OPM_M_POLL_SLP, 8);
        check(rx_en, 1'b0, "poll sleep");
        wait_mode(OPM_M_POLL_ACT, 12);
        opm_host_model_inst.send(OPM_CMD_IDLE, 3'h0, 1);
        wait_ready(20);
        opm_host_model_inst.send(OPM_CMD_TC, 3'h0, 1);
        wait_mode(OPM_M_TC, 4);
        wait_ready(80);
        shut = 1'b1;
        ticks(1);
        shut = 1'b0;
        wait_mode(OPM_M_OFF, 4);
        check(dig, 1'b0, "off supply");
        xtal = 1'b1;
        start = OPM_START_RX;
        wake(1'b1);
        wait_mode(OPM_M_RX, 300);
        opm_host_model_inst.send(OPM_CMD_IDLE, 3'h0, 1);
        wait_ready(20);
        check({crystal_osc, ana}, 2'h3, "crystal standby");
        finish_test();
    end
endmodule // opm_ctrl_tb
